// [core/idlc_top.sv]
// light_idle_level standby controller top: ahb-lite registers, mode sequencer, clock gates
// assumes a single 40 MHz clock, zero-wait ahb-lite master, synchronous inputs
`timescale 1ns/1ps
`default_nettype none
module idlc_top
	import idlc_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	input  wire logic               sub_present,
	input  wire logic               nmi_pin_req,
	input  wire logic               watchdog_nmi_request,
	input  wire logic [31:0]        irq_req,
	output logic      [N_GATES-1:0] clk_gate_en,
	output logic                    port_hold,
	output logic                    osc_pll_run,
	output logic                    idle_active
);
	idlc_state_e state;
	idlc_state_e next_state;
	logic [1:0]  mode;
	logic [4:0]  ctrl;
	logic [31:0] clksel;
	logic [31:0] irqmask;
	logic [7:0]  a_addr;
	logic        a_wr;
	logic [2:0]  nop_cnt;
	logic [N_GATES-1:0] idle_gates;
	logic [N_GATES-1:0] next_gates;

	idlc_wake_if wk ();
	idlc_wake u_wake (.w(wk));
	idlc_gate_sel u_sel (.clksel(clksel), .sub_present(sub_present), .idle_gates(idle_gates));

	assign wk.nmi_req     = nmi_pin_req;
	assign wk.wdt_req     = watchdog_nmi_request;
	assign wk.irq_req     = irq_req;
	assign wk.irq_mask    = irqmask;
	assign wk.nmi0_mask   = ctrl[CTRL_NMI0_WAKE_MASK];
	assign wk.nmi1_mask   = ctrl[CTRL_NMI1_WAKE_MASK];
	assign wk.int_mask    = ctrl[CTRL_MASKABLE_WAKE_MASK];
	assign wk.pin3_filter = ctrl[CTRL_P3FILT];

	// bus decode: take in the address phase, writes in the data phase from the captured address
	wire take;
	wire wr_mode;
	wire wr_ctrl;
	wire wr_sel;
	wire wr_mask;
	wire enter_req;
	assign take      = hsel & htrans[1] & hready;
	assign wr_mode   = a_wr & (a_addr == OFS_MODE);
	assign wr_ctrl   = a_wr & (a_addr == OFS_CTRL);
	assign wr_sel    = a_wr & (a_addr == OFS_CLKSEL);
	assign wr_mask   = a_wr & (a_addr == OFS_IRQMASK);
	assign enter_req = wr_ctrl & hwdata[CTRL_STOP_BIT] & (mode == MODE_LIGHT_IDLE) & (state == IDLC_RUN);

	// read decode in the address phase so data stands in the data phase
	wire [7:0] rd_addr;
	assign rd_addr = haddr[7:0];
	logic [31:0] rd_mux;
	always_comb begin
		if (rd_addr == OFS_MODE) begin
			rd_mux = {30'h0, mode};
		end else if (rd_addr == OFS_CTRL) begin
			rd_mux = {27'h0, ctrl};
		end else if (rd_addr == OFS_CLKSEL) begin
			rd_mux = clksel;
		end else if (rd_addr == OFS_STATUS) begin
			rd_mux = {14'h0, clk_gate_en, 2'h0, state == IDLC_IDLE, state != IDLC_RUN};
		end else if (rd_addr == OFS_IRQMASK) begin
			rd_mux = irqmask;
		end else begin
			rd_mux = 32'h00000000;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			a_addr <= 8'h00;
			a_wr   <= 1'b0;
		end else begin
			a_addr <= haddr[7:0];
			a_wr   <= take & hwrite;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take & ~hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// reset exit is the plain asynchronous reset path
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mode    <= 2'h0;
			ctrl    <= 5'h00;
			clksel  <= RST_CLKSEL;
			irqmask <= RST_IRQMASK;
		end else begin
			if (wr_mode) begin
				mode <= hwdata[MODE_HI_BIT:MODE_LO_BIT];
			end
			if (wr_ctrl) begin
				ctrl <= hwdata[4:0] & 5'h1E;
			end else if (state == IDLC_WAKE) begin
				ctrl[CTRL_STOP_BIT] <= 1'b0;
			end
			if (wr_ctrl && enter_req) begin
				ctrl[CTRL_STOP_BIT] <= 1'b1;
			end
			if (wr_sel) begin
				clksel <= hwdata;
			end
			if (wr_mask) begin
				irqmask <= hwdata;
			end
		end
	end

	// entry waits out the nop slots so the store completes first
	always_comb begin
		next_state = state;
		next_gates = clk_gate_en;
		case (state)
			IDLC_RUN: begin
				if (enter_req) begin
					next_state = IDLC_ENTER;
				end
			end
			IDLC_ENTER: begin
				if (nop_cnt == 3'(ENTRY_NOPS - 1)) begin
					next_state = IDLC_IDLE;
					next_gates = idle_gates;
				end
			end
			IDLC_IDLE: begin
				if (wk.wake) begin
					next_state = IDLC_WAKE;
					next_gates = GATES_ALL;
				end
			end
			IDLC_WAKE: begin
				next_state = IDLC_RUN;
			end
			default: begin
				next_state = IDLC_RUN;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state       <= IDLC_RUN;
			nop_cnt     <= 3'h0;
			clk_gate_en <= GATES_ALL;
			port_hold   <= 1'b0;
			idle_active <= 1'b0;
			osc_pll_run <= 1'b1;
		end else begin
			state       <= next_state;
			nop_cnt     <= (state == IDLC_ENTER) ? nop_cnt + 3'h1 : 3'h0;
			clk_gate_en <= next_gates;
			port_hold   <= (next_state == IDLC_IDLE);
			idle_active <= (next_state == IDLC_IDLE);
			osc_pll_run <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [core/idlc_pkg.sv]
// light_idle_level standby controller: shared constants and types
// assumes one 40 MHz clock and an ahb-lite register slave
package idlc_pkg;
	localparam logic [7:0] OFS_MODE     = 8'h00;
	localparam logic [7:0] OFS_CTRL     = 8'h04;
	localparam logic [7:0] OFS_CLKSEL   = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_IRQMASK  = 8'h10;
	// mode register fields
	localparam int MODE_LO_BIT = 0;
	localparam int MODE_HI_BIT = 1;
	localparam logic [1:0] MODE_LIGHT_IDLE = 2'h0;
	// control register fields
	localparam int CTRL_STOP_BIT = 0;
	localparam int CTRL_NMI0_WAKE_MASK    = 1;
	localparam int CTRL_NMI1_WAKE_MASK    = 2;
	localparam int CTRL_MASKABLE_WAKE_MASK     = 3;
	localparam int CTRL_P3FILT   = 4;
	// clock select register fields
	localparam int SEL_TMR_LO    = 0;  // 5 bits: timer on prescaler clock
	localparam int SEL_TMR_SUB   = 5;  // 5 bits: timer on subclock
	localparam int SEL_ISEL      = 10; // 5 bits: timer input select
	localparam int SEL_IVT_LO    = 15; // 3 bits: interval timer source
	localparam int SEL_WT_P3     = 18;
	localparam int SEL_UART_LO   = 19; // 3 bits: uart on prescaler clock
	localparam int SEL_UART0_EXT = 22;
	localparam int SEL_CSI_LO    = 23; // 2 bits: csi on ext clock
	localparam logic [2:0] IVT_FRH8  = 3'h0;
	localparam logic [2:0] IVT_FRL8  = 3'h1;
	localparam logic [2:0] IVT_WTIRQ = 3'h2;
	localparam logic [2:0] IVT_SUB   = 3'h3;
	localparam logic [31:0] RST_CLKSEL = 32'h00000000;
	localparam logic [31:0] RST_IRQMASK = 32'hFFFFFFFF;
	localparam int N_GATES = 14;
	// gate vector bit positions
	localparam int G_CPU  = 0;
	localparam int G_TMR  = 1;  // 5 bits
	localparam int G_IVT  = 6;
	localparam int G_WT   = 7;
	localparam int G_UART = 8;  // 3 bits
	localparam int G_CSI  = 11; // 2 bits
	localparam int G_ICU  = 13;
	localparam logic [N_GATES-1:0] GATES_ALL = 14'h3FFF;
	localparam int ENTRY_NOPS = 5;
	typedef enum logic [1:0] {IDLC_RUN, IDLC_ENTER, IDLC_IDLE, IDLC_WAKE} idlc_state_e;
endpackage

// [core/idlc_wake_if.sv]
// light_idle_level standby controller: wake request bundle between modules
// assumes request levels are synchronous to clock
`timescale 1ns/1ps
`default_nettype none
interface idlc_wake_if;
	logic        nmi_req;
	logic        wdt_req;
	logic [31:0] irq_req;
	logic [31:0] irq_mask;
	logic        nmi0_mask;
	logic        nmi1_mask;
	logic        int_mask;
	logic        pin3_filter;
	logic        wake;
	modport src (output nmi_req, wdt_req, irq_req, irq_mask, nmi0_mask, nmi1_mask, int_mask, pin3_filter,
		input wake);
	modport dec (input nmi_req, wdt_req, irq_req, irq_mask, nmi0_mask, nmi1_mask, int_mask, pin3_filter,
		output wake);
endinterface
`default_nettype wire

// [core/idlc_wake.sv]
// light_idle_level standby controller: combinational wake decision
// assumes irq_req bit 3 is the external pin 3 request
`timescale 1ns/1ps
`default_nettype none
module idlc_wake
	import idlc_pkg::*;
(
	idlc_wake_if.dec w
);
	wire        nmi_ok;
	wire [31:0] irq_ok;
	assign nmi_ok = (w.nmi_req & ~w.nmi0_mask) | (w.wdt_req & ~w.nmi1_mask);
	// pin 3 edges cannot wake while its noise filter is on
	assign irq_ok = w.irq_req & ~w.irq_mask & ~({31'h0, w.pin3_filter} << 3);
	// lower priority requests still wake; they stay pending in the irq controller
	assign w.wake = nmi_ok | (~w.int_mask & (|irq_ok));
endmodule
`default_nettype wire

// [core/idlc_gate_sel.sv]
// light_idle_level standby controller: per peripheral gate selection while idle
// assumes select bits are stable during idle
`timescale 1ns/1ps
`default_nettype none
module idlc_gate_sel
	import idlc_pkg::*;
(
	input  wire logic [31:0]        clksel,
	input  wire logic               sub_present,
	output logic      [N_GATES-1:0] idle_gates
);
	wire [4:0] tmr_sub_ok;
	wire [2:0] ivt_src;
	genvar i;
	assign ivt_src = clksel[SEL_IVT_LO +: 3];
	generate
		for (i = 0; i < 5; i++) begin : g_tmr
			// only odd channels can use the subclock, and only with input select set
			assign tmr_sub_ok[i] = sub_present & ((i % 2) == 1) & clksel[SEL_ISEL + i] & clksel[SEL_TMR_SUB + i];
			assign idle_gates[G_TMR + i] = clksel[SEL_TMR_LO + i] | tmr_sub_ok[i];
		end
	endgenerate
	assign idle_gates[G_CPU] = 1'b0;
	assign idle_gates[G_IVT] = (ivt_src == IVT_FRH8) | (ivt_src == IVT_FRL8) | (ivt_src == IVT_WTIRQ)
		| (sub_present & (ivt_src == IVT_SUB));
	assign idle_gates[G_WT] = sub_present | clksel[SEL_WT_P3];
	assign idle_gates[G_UART] = clksel[SEL_UART_LO] | clksel[SEL_UART0_EXT];
	assign idle_gates[G_UART+1 +: 2] = clksel[SEL_UART_LO+1 +: 2];
	assign idle_gates[G_CSI +: 2] = clksel[SEL_CSI_LO +: 2];
	assign idle_gates[G_ICU] = 1'b0;
endmodule
`default_nettype wire

// [verification/idlc_req_src.sv]
// wake request source model: core and peripherals raising wake requests
// assumes one-cycle set pulses after a rising edge; clr models servicing
`timescale 1ns/1ps
`default_nettype none
module idlc_req_src (
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        set_nmi,
	input  wire logic        set_wdt,
	input  wire logic [31:0] set_irq,
	input  wire logic        clr,
	output logic             nmi,
	output logic             wdt,
	output logic      [31:0] irq
);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{nmi, wdt, irq} <= 34'h0;
		end else begin
			{nmi, wdt, irq} <= clr ? 34'h0 : {nmi | set_nmi, wdt | set_wdt, irq | set_irq};
		end
	end
endmodule
`default_nettype wire

// [verification/idlc_checker.sv]
// light_idle_level controller checker: port-level timing and gating relations
// assumes single zero-wait writes and no register writes while idle
`timescale 1ns/1ps
`default_nettype none
module idlc_checker
	import idlc_pkg::*;
(
	input wire logic               clock,
	input wire logic               arst_n,
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic               sub_present,
	input wire logic               nmi_pin_req,
	input wire logic               watchdog_nmi_request,
	input wire logic [31:0]        irq_req,
	input wire logic [N_GATES-1:0] clk_gate_en,
	input wire logic               port_hold,
	input wire logic               osc_pll_run,
	input wire logic               idle_active
);
	logic        wr_p;
	logic [7:0]  wa;
	logic [1:0]  mode;
	logic [4:0]  ctrl;
	logic [31:0] sel;
	logic [31:0] msk;
	logic        wake;
	// shadow copies of the written registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_p <= 1'b0;
			wa   <= 8'h00;
			mode <= 2'h0;
			ctrl <= 5'h00;
			sel  <= RST_CLKSEL;
			msk  <= RST_IRQMASK;
		end else if (hready) begin
			wr_p <= hsel & htrans[1] & hwrite;
			wa   <= haddr[7:0];
			mode <= (wr_p && wa == OFS_MODE) ? hwdata[1:0] : mode;
			ctrl <= (wr_p && wa == OFS_CTRL) ? hwdata[4:0] : ctrl;
			sel  <= (wr_p && wa == OFS_CLKSEL) ? hwdata : sel;
			msk  <= (wr_p && wa == OFS_IRQMASK) ? hwdata : msk;
		end
	end
	assign wake = (nmi_pin_req & ~ctrl[CTRL_NMI0_WAKE_MASK]) | (watchdog_nmi_request & ~ctrl[CTRL_NMI1_WAKE_MASK])
		| (~ctrl[CTRL_MASKABLE_WAKE_MASK] & |(irq_req & ~msk & ~{28'h0, ctrl[CTRL_P3FILT], 3'h0}));
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_stop;
		wr_p && wa == OFS_CTRL && hwdata[CTRL_STOP_BIT] && mode == MODE_LIGHT_IDLE && !idle_active;
	endsequence
	sequence s_settle;
		!idle_active [*5] ##1 idle_active;
	endsequence
	a_entry_delay: assert property (s_stop |=> s_settle) else $error("idle entry timing wrong");
	a_wake_exit: assert property (idle_active && wake |=> !idle_active) else $error("no exit on wake");
	a_masked_stay: assert property (idle_active && !wake |=> idle_active) else $error("exit on masked");
	a_run_gates: assert property (!idle_active |-> clk_gate_en == GATES_ALL) else $error("gates off");
	a_hold_port: assert property (port_hold == idle_active) else $error("port hold wrong");
	a_osc_run: assert property (osc_pll_run) else $error("oscillator stopped");
	a_core_off: assert property (idle_active |-> !clk_gate_en[G_CPU] && !clk_gate_en[G_ICU])
		else $error("cpu or icu clock on");
	a_timer_gate: assert property (idle_active |-> clk_gate_en[G_TMR+:5] ==
		(sel[4:0] | ({5{sub_present}} & sel[9:5] & sel[14:10] & 5'h0A))) else $error("timer gate");
	a_serial_gate: assert property (idle_active |-> clk_gate_en[G_UART+:5] ==
		{sel[24:23], sel[21:20], sel[19] | sel[22]}) else $error("serial gate");
	a_slow_gate: assert property (idle_active |-> clk_gate_en[G_IVT+:2] == {sub_present | sel[18],
		sel[17:15] < 3'h3 || (sel[17:15] == 3'h3 && sub_present)}) else $error("slow gate");
endmodule
bind idlc_top idlc_checker u_idlc_checker (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .sub_present, .nmi_pin_req, .watchdog_nmi_request, .irq_req, .clk_gate_en, .port_hold,
	.osc_pll_run, .idle_active);
`default_nettype wire

// [verification/tb.sv]
// light_idle_level controller testbench: register bus, idle entry, wake and gating
// assumes the request source model stands in for core and peripherals
`timescale 1ns/1ps
`default_nettype none
module tb
	import idlc_pkg::*;
;
	logic               clock = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, sub_present = 1'b0;
	logic               s_nmi = 1'b0, s_wdt = 1'b0, clr = 1'b0;
	logic [1:0]         htrans = 2'h0;
	logic [31:0]        haddr = 32'h0, hwdata = 32'h0, s_irq = 32'h0, q, hrdata, irq_req;
	logic               hreadyout, hresp, nmi, wdt, port_hold, osc_pll_run, idle_active;
	logic [N_GATES-1:0] clk_gate_en;
	int                 miscompares = 0, num_checks = 0;
	always #12.5 clock = ~clock;
	idlc_top u_idlc_top (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .sub_present, .nmi_pin_req(nmi),
		.watchdog_nmi_request(wdt), .irq_req, .clk_gate_en, .port_hold, .osc_pll_run, .idle_active);
	idlc_req_src u_idlc_req_src (.clock, .arst_n, .set_nmi(s_nmi), .set_wdt(s_wdt), .set_irq(s_irq),
		.clr, .nmi, .wdt, .irq(irq_req));
	task automatic stop_test();
		if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic [31:0] mk(input logic [4:0] lo, sb, is, input logic [2:0] iv, input logic wp,
		input logic [2:0] ul, input logic ue, input logic [1:0] cs);
		return {7'h0, cs, ue, ul, wp, iv, is, sb, lo};
	endfunction
	task automatic go_idle(input logic [31:0] sel, input logic [4:0] c, input logic [13:0] g);
		int n = 0;
		bus(1'b1, OFS_CLKSEL, sel);
		bus(1'b1, OFS_IRQMASK, 32'hFFFFFFF6);
		// converter taken as stopped by software before entry
		bus(1'b1, OFS_MODE, {30'h0, MODE_LIGHT_IDLE});
		bus(1'b1, OFS_CTRL, {27'h0, c} | 32'h1);
		while (idle_active !== 1'b1 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk("entry cycles", 32'(ENTRY_NOPS), 32'(n));
		chk("port hold", 32'h1, {31'h0, port_hold});
		chk("idle gates", {18'h0, g}, {18'h0, clk_gate_en});
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("idle status", {14'h0, g, 4'h3}, q);
	endtask
	task automatic fire(input logic n, input logic w, input logic [31:0] i, input logic stay);
		s_nmi <= n;
		s_wdt <= w;
		s_irq <= i;
		@(posedge clock);
		s_nmi <= 1'b0;
		s_wdt <= 1'b0;
		s_irq <= 32'h0;
		repeat (3) @(posedge clock);
		#1;
		chk("idle after request", {31'h0, stay}, {31'h0, idle_active});
		if (!stay) chk("gates after wake", {18'h0, GATES_ALL}, {18'h0, clk_gate_en});
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
	endtask
	task automatic t_reset();
		chk("gates at reset", {18'h0, GATES_ALL}, {18'h0, clk_gate_en});
		chk("pll run", 32'h1, {31'h0, osc_pll_run});
		bus(1'b0, OFS_IRQMASK, 32'h0);
		chk("irq mask reset", RST_IRQMASK, q);
		bus(1'b0, OFS_CLKSEL, 32'h0);
		chk("clksel reset", RST_CLKSEL, q);
		bus(1'b1, 8'h40, 32'hFFFFFFFF);
		bus(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h0, q);
		chk("response", 32'h0, {31'h0, hresp});
		bus(1'b1, OFS_MODE, 32'h2);
		bus(1'b1, OFS_CTRL, 32'h1);
		repeat (10) @(posedge clock);
		#1;
		chk("other mode no idle", 32'h0, {31'h0, idle_active});
	endtask
	task automatic t_nosub();
		sub_present <= 1'b0;
		go_idle(mk(5'h05, 5'h0A, 5'h0A, IVT_SUB, 1'b1, 3'h6, 1'b1, 2'h1), 5'h0,
			{1'b0, 2'h1, 3'h7, 1'b1, 1'b0, 5'h05, 1'b0});
		fire(1'b1, 1'b0, 32'h0, 1'b0);
	endtask
	task automatic t_sub();
		sub_present <= 1'b1;
		go_idle(mk(5'h05, 5'h0A, 5'h02, IVT_SUB, 1'b0, 3'h1, 1'b0, 2'h2), 5'h10,
			{1'b0, 2'h2, 3'h1, 1'b1, 1'b1, 5'h07, 1'b0});
		fire(1'b0, 1'b0, 32'h20, 1'b1);
		fire(1'b0, 1'b0, 32'h8, 1'b1);
		fire(1'b0, 1'b1, 32'h0, 1'b0);
	endtask
	task automatic t_ivt();
		sub_present <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			go_idle(mk(5'h0, 5'h0, 5'h0, 3'(i), 1'b0, 3'h0, 1'b0, 2'h0), 5'h0, {7'h0, i < 3, 6'h0});
			fire(1'b0, 1'b0, 32'h1, 1'b0);
		end
	endtask
	task automatic t_masked_reset();
		go_idle(mk(5'h0, 5'h0, 5'h0, IVT_FRH8, 1'b0, 3'h0, 1'b0, 2'h0), 5'h0E, 14'h0040);
		fire(1'b1, 1'b1, 32'h1, 1'b1);
		arst_n <= 1'b0;
		@(posedge clock);
		#1;
		chk("reset exit idle", 32'h0, {31'h0, idle_active});
		chk("reset exit gates", {18'h0, GATES_ALL}, {18'h0, clk_gate_en});
		arst_n <= 1'b1;
		@(posedge clock);
	endtask
	initial begin
		#100000;
		miscompares++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_nosub();
		t_sub();
		t_ivt();
		t_masked_reset();
		stop_test();
	end
endmodule
`default_nettype wire
